// File: rsr_pkg.sv
/*
  rsr_pkg: constants and carriers for the regulator status, ramp-rate and
  target-voltage register bank.
  assumes: used by rsr_top and rsr_ramp_decode; no imports anywhere.
*/
package rsr_pkg;
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_RAMP = 2'h1;
  localparam logic [1:0] REG_TARGET = 2'h2;
  localparam int ST_INT_ERR = 7;
  localparam int ST_THERMAL = 5;
  localparam int ST_LOW = 4;
  localparam int ST_HIGH = 3;
  localparam int ST_OVERCUR = 2;
  localparam int ST_CEILING = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int RAMP_W = 4;
  localparam int CODE_W = 7;
  localparam logic [3:0] RAMP_LAST_LEGAL = 4'h9;
  // rates in units of 0.5 mV/us; 12.5 mV step scales by 5/4
  localparam int RATE_W = 8;
  localparam int RATE_SCALE_NUM = 5;
  localparam int RATE_SCALE_DEN = 4;

  typedef struct packed {
    logic [RATE_W-1:0] soft_start;
    logic [RATE_W-1:0] dynamic;
  } rsr_rates_s;

  typedef struct packed {
    logic internal_trim_error;
    logic thermal_shutdown_flag;
    logic output_low_flag;
    logic output_high_flag;
    logic overcurrent_flag;
    logic ceiling_error_flag;
  } rsr_status_s;
endpackage

// File: rsr_sticky.sv
/*
  rsr_sticky: one flag latched by an event, cleared by a status read.
  assumes: event and clear are one-cycle qualifiers in the sys_clk domain.
*/
`timescale 1ns/1ps
module rsr_sticky (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic event_in,
  input wire logic clear_in,
  output logic flag
);
  logic flag_next;

  // an event in the clearing cycle survives the read
  always_comb begin
    flag_next = flag;
    if (clear_in) begin
      flag_next = 1'b0;
    end
    if (event_in) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      flag <= 1'b0;
    end else begin
      flag <= flag_next;
    end
  end
endmodule

// File: rsr_ramp_decode.sv
/*
  rsr_ramp_decode: ramp code plus step select to soft-start and dynamic rates.
  assumes: rates in 0.5 mV/us units; reserved codes give zero.
*/
`timescale 1ns/1ps
module rsr_ramp_decode (
  input wire logic [rsr_pkg::RAMP_W-1:0] code,
  input wire logic step_size_select,
  output rsr_pkg::rsr_rates_s rates
);
  rsr_pkg::rsr_rates_s base;
  logic [rsr_pkg::RATE_W+2:0] ss_scaled;
  logic [rsr_pkg::RATE_W+2:0] dyn_scaled;

  always_comb begin
    unique case (code)
      4'h0: base = '{8'h2C, 8'h2C};
      4'h1: base = '{8'h16, 8'h2C};
      4'h2: base = '{8'h0B, 8'h2C};
      4'h3: base = '{8'h16, 8'h16};
      4'h4: base = '{8'h0B, 8'h16};
      4'h5: base = '{8'h58, 8'h58};
      4'h6: base = '{8'h2C, 8'h58};
      4'h7: base = '{8'h16, 8'h58};
      4'h8: base = '{8'h0B, 8'h58};
      4'h9: base = '{8'h0B, 8'h0B};
      default: base = '{8'h00, 8'h00};
    endcase
  end

  // 1.25x for the coarse step; truncation loses under 0.5 mV/us
  always_comb begin
    ss_scaled = {3'h0, base.soft_start};
    dyn_scaled = {3'h0, base.dynamic};
    if (step_size_select) begin
      ss_scaled = 11'((ss_scaled * rsr_pkg::RATE_SCALE_NUM) / rsr_pkg::RATE_SCALE_DEN);
      dyn_scaled = 11'((dyn_scaled * rsr_pkg::RATE_SCALE_NUM) / rsr_pkg::RATE_SCALE_DEN);
    end
    rates.soft_start = ss_scaled[rsr_pkg::RATE_W-1:0];
    rates.dynamic = dyn_scaled[rsr_pkg::RATE_W-1:0];
  end
endmodule

// File: rsr_top.sv
/*
  rsr_top: status, ramp-rate and target-voltage registers of a step-down
  regulator, behind a simple register port fed by the serial bus engine.
  assumes: all inputs synchronous to sys_clk; otp values steady at reset
  release; serial engine raises reg_rd/reg_wr for one cycle per access.
*/
`timescale 1ns/1ps
module rsr_top (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [rsr_pkg::RAMP_W-1:0] otp_ramp_code,
  input wire logic [rsr_pkg::CODE_W-1:0] otp_voltage_code,
  input wire logic [rsr_pkg::CODE_W-1:0] voltage_ceiling_code,
  input wire logic step_size_select,
  input wire logic normal_mode,
  input wire logic trim_incomplete,
  input wire logic thermal_event,
  input wire logic overcurrent_event,
  input wire logic output_below_target,
  input wire logic output_above_target,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic [rsr_pkg::RAMP_W-1:0] ramp_rate_code,
  output logic [rsr_pkg::CODE_W-1:0] applied_voltage_code,
  output logic ceiling_error_flag,
  output logic [rsr_pkg::RATE_W-1:0] soft_start_rate,
  output logic [rsr_pkg::RATE_W-1:0] dynamic_voltage_ramp
);
  logic status_read;
  logic load_reg;
  logic load_next;
  logic [rsr_pkg::RAMP_W-1:0] ramp_reg;
  logic [rsr_pkg::RAMP_W-1:0] ramp_next;
  logic [rsr_pkg::CODE_W-1:0] target_reg;
  logic [rsr_pkg::CODE_W-1:0] target_next;
  rsr_pkg::rsr_status_s stat_reg;
  rsr_pkg::rsr_status_s stat_next;
  logic thermal_latched;
  logic overcur_latched;
  logic over_ceiling;
  logic [7:0] status_byte;
  logic [7:0] rdata_next;
  logic rvalid_next;
  logic [rsr_pkg::CODE_W-1:0] applied_next;
  rsr_pkg::rsr_rates_s rates;
  rsr_pkg::rsr_rates_s rates_reg;

  assign status_read = reg_rd && (reg_addr == rsr_pkg::REG_STATUS);
  // ceiling compare only counts in normal mode
  assign over_ceiling = normal_mode && (target_reg > voltage_ceiling_code);

  rsr_sticky u_thermal (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .event_in(thermal_event),
    .clear_in(status_read),
    .flag(thermal_latched)
  );

  rsr_sticky u_overcur (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .event_in(overcurrent_event),
    .clear_in(status_read),
    .flag(overcur_latched)
  );

  rsr_ramp_decode u_decode (
    .code(ramp_reg),
    .step_size_select(step_size_select),
    .rates(rates)
  );

  // otp values are taken on the first clock after reset release
  always_comb begin
    load_next = 1'b1;
    ramp_next = ramp_reg;
    target_next = target_reg;
    if (!load_reg) begin
      ramp_next = otp_ramp_code;
      target_next = otp_voltage_code;
    end else if (reg_wr) begin
      if (reg_addr == rsr_pkg::REG_RAMP) begin
        ramp_next = reg_wdata[rsr_pkg::RAMP_W-1:0];
      end
      if (reg_addr == rsr_pkg::REG_TARGET) begin
        target_next = reg_wdata[rsr_pkg::CODE_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      load_reg <= 1'b0;
      ramp_reg <= '0;
      target_reg <= '0;
    end else begin
      load_reg <= load_next;
      ramp_reg <= ramp_next;
      target_reg <= target_next;
    end
  end

  // live flags sampled each cycle, so a read sees last cycle's level
  always_comb begin
    stat_next.internal_trim_error = trim_incomplete;
    stat_next.thermal_shutdown_flag = thermal_latched;
    stat_next.output_low_flag = output_below_target;
    stat_next.output_high_flag = output_above_target;
    stat_next.overcurrent_flag = overcur_latched;
    stat_next.ceiling_error_flag = over_ceiling;
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[rsr_pkg::ST_INT_ERR] = stat_reg.internal_trim_error;
    status_byte[rsr_pkg::ST_THERMAL] = stat_reg.thermal_shutdown_flag;
    status_byte[rsr_pkg::ST_LOW] = stat_reg.output_low_flag;
    status_byte[rsr_pkg::ST_HIGH] = stat_reg.output_high_flag;
    status_byte[rsr_pkg::ST_OVERCUR] = stat_reg.overcurrent_flag;
    status_byte[rsr_pkg::ST_CEILING] = stat_reg.ceiling_error_flag;
  end

  // in normal mode only, clamp keeps the converter at or below the ceiling even on bad writes
  always_comb begin
    applied_next = over_ceiling ? voltage_ceiling_code : target_reg;
    rvalid_next = reg_rd;
    rdata_next = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        rsr_pkg::REG_STATUS: rdata_next = status_byte;
        rsr_pkg::REG_RAMP: rdata_next = {4'h0, ramp_reg};
        rsr_pkg::REG_TARGET: rdata_next = {1'b0, target_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stat_reg <= '0;
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      applied_voltage_code <= '0;
      rates_reg <= '0;
    end else begin
      stat_reg <= stat_next;
      reg_rdata <= rdata_next;
      reg_rvalid <= rvalid_next;
      applied_voltage_code <= applied_next;
      rates_reg <= rates;
    end
  end

  assign ramp_rate_code = ramp_reg;
  assign ceiling_error_flag = stat_reg.ceiling_error_flag;
  assign soft_start_rate = rates_reg.soft_start;
  assign dynamic_voltage_ramp = rates_reg.dynamic;
endmodule

// File: rsr_chk.sv
/* rsr_chk: port checks for rsr_top.
   assumes: bound to rsr_top, one clock domain. */
`timescale 1ns/1ps
module rsr_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [6:0] voltage_ceiling_code,
  input wire logic normal_mode,
  input wire logic trim_incomplete,
  input wire logic thermal_event,
  input wire logic overcurrent_event,
  input wire logic output_below_target,
  input wire logic output_above_target,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [3:0] ramp_rate_code,
  input wire logic [6:0] applied_voltage_code,
  input wire logic ceiling_error_flag,
  input wire logic [7:0] soft_start_rate,
  input wire logic [7:0] dynamic_voltage_ramp
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire rd0 = reg_rd && reg_addr == 2'h0;
  wire ev = thermal_event || overcurrent_event;
  property p_zero; reg_rvalid && $past(reg_addr) == 2'h0 |-> !reg_rdata[6] && !reg_rdata[0];
  endproperty
  property p_trim; rd0 && $past(rst_b) && $past(trim_incomplete) |=> reg_rdata[7]; endproperty
  property p_live; rd0 && $past(rst_b) |=> reg_rdata[4:3] ==
    {$past(output_below_target, 2), $past(output_above_target, 2)}; endproperty
  property p_thr; thermal_event ##2 rd0 |=> reg_rdata[5]; endproperty
  property p_oc; overcurrent_event ##2 rd0 |=> reg_rdata[2]; endproperty
  // three-cycle gap: the status copy lags the sticky flags by one cycle
  property p_clr; (rd0 && !ev) ##1 (!ev [*2]) ##1 rd0 |=> !reg_rdata[5] && !reg_rdata[2];
  endproperty
  property p_clamp; $past(normal_mode) && $past(rst_b) |->
    applied_voltage_code <= $past(voltage_ceiling_code); endproperty
  property p_ramp; reg_wr && reg_addr == 2'h1 && $past(rst_b) |=>
    ramp_rate_code == $past(reg_wdata[3:0]); endproperty
  property p_rsv; ramp_rate_code <= 4'h9 && $past(rst_b) |=> soft_start_rate != 8'h00 &&
    dynamic_voltage_ramp != 8'h00; endproperty
  property p_unm; reg_rd && reg_addr == 2'h3 |=> reg_rdata == 8'h00; endproperty
  a_zero: assert property (p_zero) else $error("fixed zero bits set");
  a_trim: assert property (p_trim) else $error("trim bit missing");
  a_live: assert property (p_live) else $error("live flags wrong");
  a_thr: assert property (p_thr) else $error("thermal flag lost");
  a_oc: assert property (p_oc) else $error("overcurrent flag lost");
  a_clr: assert property (p_clr) else $error("flags not cleared by read");
  a_clamp: assert property (p_clamp) else $error("applied code above ceiling");
  a_ramp: assert property (p_ramp) else $error("ramp code not written");
  a_rsv: assert property (p_rsv) else $error("legal code gives no rate");
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  c_thr: cover property (thermal_event ##2 rd0);
  c_ceil: cover property (ceiling_error_flag);
  c_rsv: cover property (ramp_rate_code == 4'h9);
endmodule
bind rsr_top rsr_chk u_chk (.*);

// File: rsr_host.sv
/* rsr_host: host side of the register port, one byte per access.
   assumes: strobes taken on the rising edge, answer one cycle later. */
`timescale 1ns/1ps
module rsr_host (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [1:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_addr = 2'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // idle bus shows inverted values so stale data never looks valid
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // reserved bits are only compared by the bench, never acted on
  task automatic rd(input logic [1:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge sys_clk);
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata;
      end
    end
  endtask
endmodule

// File: regulator_status_slew_regs_tb_top.sv
/* regulator_status_slew_regs_tb_top: register sequences against rsr_top.
   assumes: rsr_host drives the port; rsr_chk is bound. */
`timescale 1ns/1ps
module regulator_status_slew_regs_tb_top;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] reg_addr;
  logic reg_wr, reg_rd, reg_rvalid, ceiling_error_flag;
  logic [7:0] reg_wdata, reg_rdata, d, soft_start_rate, dynamic_voltage_ramp;
  logic [3:0] otp_ramp_code = 4'h3, ramp_rate_code;
  logic [6:0] otp_voltage_code = 7'h20, voltage_ceiling_code = 7'h7F, applied_voltage_code;
  logic step_size_select = 0, normal_mode = 0, trim_incomplete = 0, thermal_event = 0;
  logic overcurrent_event = 0, output_below_target = 0, output_above_target = 0;
  int error_cnt = 0, num_checks = 0;
  int ss[10] = '{44, 22, 11, 22, 11, 88, 44, 22, 11, 11};
  int dv[10] = '{44, 44, 44, 22, 22, 88, 88, 88, 88, 11};
  bit ok;
  rsr_top uut (.*);
  rsr_host host (.*);
  initial forever #25 sys_clk = ~sys_clk;
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    host.rd(a, d, ok);
    if (!ok) begin
      error_cnt++;
      wrap_up();
    end else chk("read", d, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  initial begin
    tick(6);
    rst_b <= 1'b1;
    tick(1);
    rd_chk(2'h0, 8'h00);
    rd_chk(2'h1, 8'h03);
    rd_chk(2'h2, 8'h20);
    tick(1);
    trim_incomplete <= 1'b1;
    output_below_target <= 1'b1;
    rd_chk(2'h0, 8'h90);
    tick(1);
    trim_incomplete <= 1'b0;
    output_below_target <= 1'b0;
    output_above_target <= 1'b1;
    rd_chk(2'h0, 8'h08);
    tick(1);
    output_above_target <= 1'b0;
    thermal_event <= 1'b1;
    overcurrent_event <= 1'b1;
    tick(1);
    thermal_event <= 1'b0;
    overcurrent_event <= 1'b0;
    rd_chk(2'h0, 8'h24);
    tick(1);
    rd_chk(2'h0, 8'h00);
    $display("test status done");
    // host keeps off the reserved codes 10 to 15
    for (int s = 0; s < 2; s++) for (int i = 0; i < 10; i++) begin
      tick(1);
      step_size_select <= s[0];
      host.wr(2'h1, {4'hA, i[3:0]});
      tick(3);
      rd_chk(2'h1, {4'h0, i[3:0]});
      chk("soft", soft_start_rate, i < 10 ? 8'(ss[i] * (4 + s) / 4) : 8'h00);
      chk("dyn", dynamic_voltage_ramp, i < 10 ? 8'(dv[i] * (4 + s) / 4) : 8'h00);
    end
    $display("test ramp done");
    tick(1);
    normal_mode <= 1'b1;
    voltage_ceiling_code <= 7'h30;
    host.wr(2'h2, 8'hC0);
    tick(2);
    rd_chk(2'h2, 8'h40);
    chk("applied", {1'b0, applied_voltage_code}, 8'h30);
    rd_chk(2'h0, 8'h02);
    host.wr(2'h2, 8'h10);
    tick(3);
    // look mid-cycle, away from the edge that launches the outputs
    @(negedge sys_clk);
    chk("flag", {7'h00, ceiling_error_flag}, 8'h00);
    chk("applied", {1'b0, applied_voltage_code}, 8'h10);
    tick(1);
    normal_mode <= 1'b0;
    host.wr(2'h2, 8'h40);
    tick(3);
    @(negedge sys_clk);
    chk("flag", {7'h00, ceiling_error_flag}, 8'h00);
    host.wr(2'h0, 8'hFF);
    rd_chk(2'h3, 8'h00);
    rd_chk(2'h0, 8'h00);
    $display("test ceiling done");
    wrap_up();
  end
endmodule
